// ===== core/pdc_power_ctrl.sv
// Operation
// - Regulator power-mode bit one puts regulator in low-current state during Sleep
// - Reserved regulator bit 0 reads one; writes keep it set
// - Idle-select set: SLEEP stops only the CPU clock
// - Idle-select clear: SLEEP halts CPU and peripheral clocks
// - Doze enabled: CPU cycles run only at the doze ratio
// - Doze disabled: CPU runs every cycle at full speed
// - Recover-on-interrupt set: interrupt entry clears doze enable
// - Recover-on-interrupt clear: interrupt entry leaves doze enable alone
// - Doze-on-exit set: return from interrupt sets doze enable
// - Doze-on-exit clear: return from interrupt leaves doze enable alone
// - Ratio code 000 gives 1:2, doubling per code up to 1:256
// - Debug forces full speed without changing stored doze enable
// - Waking from low-current Sleep adds a stabilisation delay
// - SLEEP with an interrupt already pending acts as no-operation
//
// The address map and the APB slave port were decided locally.
`include "pdc_cfg.svh"

module pdc_power_ctrl
  import pdc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        powerOnReset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleepExec,
  input  wire logic        intPending,
  input  wire logic        wakeEvent,
  input  wire logic        isrEntry,
  input  wire logic        returnFromInterrupt,
  input  wire logic        inCircuitDebug,
  output logic             cpuClkEn,
  output logic             periphClkEn,
  output logic             regLowCurrent
);

  function automatic logic [2:0] regHit(input logic [7:0] a);
    regHit = {a == `PDC_OFS_STATUS, a == `PDC_OFS_DOZECTL, a == `PDC_OFS_REGCTL};
  endfunction

  pdc_state_e state_q;
  pdc_state_e state_d;
  logic       regPowerMode_q;
  logic       idleSelect_q;
  logic       dozeEnable_q;
  logic       dozeEnable_d;
  logic       recoverOnInterrupt_q;
  logic       dozeOnExit_q;
  pdc_ratio_t dozeRatio_q;
  logic [31:0] prdata_q;

  logic [2:0]  hit;
  logic        setupPhase;
  logic        wrAccess;
  logic        wrReg;
  logic        wrDoze;
  logic [31:0] rdMux;
  logic [7:0]  regCtlRd;
  logic [7:0]  dozeCtlRd;
  logic [7:0]  statusRd;
  logic        dozeActive;
  logic        cycleTick;
  logic        wakeStart;
  logic        wakeDone;
  logic        sleepTaken;
  logic        isrClear;
  logic        retfieSet;

  // Bus decode, zero wait states
  assign hit        = regHit(paddr);
  assign setupPhase = psel && !penable;
  assign wrAccess   = psel && penable && pwrite;
  assign wrReg      = wrAccess && hit[0];
  assign wrDoze     = wrAccess && hit[1];
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && (hit == 3'b000);
  assign prdata     = prdata_q;

  // Read views
  assign regCtlRd  = {6'h00, regPowerMode_q, 1'b1};
  assign dozeCtlRd = {idleSelect_q, dozeEnable_q, recoverOnInterrupt_q,
                      dozeOnExit_q, 1'b0, dozeRatio_q};
  assign statusRd  = {3'h0, dozeActive, state_q};
  assign rdMux     = hit[0] ? {24'h000000, regCtlRd}  :
                     hit[1] ? {24'h000000, dozeCtlRd} :
                     hit[2] ? {24'h000000, statusRd}  : 32'h00000000;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prdata_q <= 32'h00000000;
    end else if (setupPhase && !pwrite) begin
      prdata_q <= rdMux;
    end
  end

  // Regulator control register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      regPowerMode_q <= `PDC_REG_PM_RST;
    end else if (wrReg) begin
      regPowerMode_q <= pwdata[`PDC_REG_PM_BIT];
    end
  end

  // Doze enable: hardware set beats hardware clear beats software write
  assign isrClear     = isrEntry && recoverOnInterrupt_q;
  assign retfieSet    = returnFromInterrupt && dozeOnExit_q;
  assign dozeEnable_d = retfieSet ? 1'b1 :
                        isrClear  ? 1'b0 :
                        wrDoze    ? pwdata[`PDC_DZ_EN_BIT] : dozeEnable_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dozeEnable_q         <= 1'b0;
      recoverOnInterrupt_q <= 1'b0;
      dozeOnExit_q         <= 1'b0;
      dozeRatio_q          <= `PDC_DZ_RATIO_RST;
    end else begin
      dozeEnable_q <= dozeEnable_d;
      if (wrDoze) begin
        recoverOnInterrupt_q <= pwdata[`PDC_DZ_ROI_BIT];
        dozeOnExit_q         <= pwdata[`PDC_DZ_DOE_BIT];
        dozeRatio_q          <= pwdata[`PDC_DZ_RATIO_MSB:`PDC_DZ_RATIO_LSB];
      end
    end
  end

  // Idle select clears on power-on and brown-out only
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      if (powerOnReset) begin
        idleSelect_q <= 1'b0;
      end
    end else if (wrDoze) begin
      idleSelect_q <= pwdata[`PDC_DZ_IDLE_BIT];
    end
  end

  // Power state sequencing
  assign sleepTaken = sleepExec && !intPending;
  assign wakeStart  = (state_q == PDC_SLEEP) && wakeEvent && regPowerMode_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PDC_RUN: begin
        if (sleepTaken) begin
          state_d = idleSelect_q ? PDC_IDLE : PDC_SLEEP;
        end
      end
      PDC_IDLE: begin
        if (wakeEvent) begin
          state_d = PDC_RUN;
        end
      end
      PDC_SLEEP: begin
        if (wakeEvent) begin
          state_d = regPowerMode_q ? PDC_WAKE : PDC_RUN;
        end
      end
      PDC_WAKE: begin
        if (wakeDone) begin
          state_d = PDC_RUN;
        end
      end
      default: begin
        state_d = PDC_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= PDC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  pdc_doze_throttle u_pdc_doze_throttle (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .ratioCode (dozeRatio_q),
    .cycleTick (cycleTick)
  );

  pdc_wake_delay u_pdc_wake_delay (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (wakeStart),
    .done     (wakeDone)
  );

  // Clock gating and regulator state
  assign dozeActive    = dozeEnable_q && !inCircuitDebug;
  assign cpuClkEn      = (state_q == PDC_RUN) && (!dozeActive || cycleTick);
  assign periphClkEn   = (state_q == PDC_RUN) || (state_q == PDC_IDLE);
  assign regLowCurrent = (state_q == PDC_SLEEP) && regPowerMode_q;

  // Independent measure of the throttle period for the checks below
  logic [7:0] tickGap_q;
  pdc_ratio_t tickRatio_q;
  logic       tickSeen_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tickGap_q   <= 8'h00;
      tickRatio_q <= `PDC_DZ_RATIO_RST;
      tickSeen_q  <= 1'b0;
    end else if (cycleTick) begin
      tickGap_q   <= 8'h00;
      tickRatio_q <= dozeRatio_q;
      tickSeen_q  <= 1'b1;
    end else begin
      tickGap_q   <= tickGap_q + 8'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_lowcur;
    (state_q == PDC_SLEEP) |-> (regLowCurrent == regPowerMode_q);
  endproperty
  a_lowcur: assert property (p_lowcur) else $error("regulator mode wrong in sleep");

  property p_rsvd;
    psel && penable && !pwrite && hit[0] |-> prdata[0];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit not one");

  property p_idle;
    (state_q == PDC_IDLE) |-> periphClkEn && !cpuClkEn;
  endproperty
  a_idle: assert property (p_idle) else $error("idle clocks wrong");

  property p_sleep;
    (state_q == PDC_RUN) && sleepTaken && !idleSelect_q |=> !periphClkEn && !cpuClkEn;
  endproperty
  a_sleep: assert property (p_sleep) else $error("full sleep clocks wrong");

  property p_dozegap;
    (state_q == PDC_RUN) && dozeActive && cpuClkEn && $stable(dozeActive) ##1
      (state_q == PDC_RUN) && dozeActive |-> !cpuClkEn;
  endproperty
  a_dozegap: assert property (p_dozegap) else $error("doze ran back to back");

  property p_full;
    (state_q == PDC_RUN) && !dozeEnable_q |-> cpuClkEn;
  endproperty
  a_full: assert property (p_full) else $error("full speed throttled");

  property p_roi;
    isrEntry && recoverOnInterrupt_q && !retfieSet |=> !dozeEnable_q;
  endproperty
  a_roi: assert property (p_roi) else $error("interrupt entry kept doze");

  property p_noroi;
    isrEntry && !recoverOnInterrupt_q && !retfieSet && !wrDoze |=> $stable(dozeEnable_q);
  endproperty
  a_noroi: assert property (p_noroi) else $error("interrupt entry changed doze");

  property p_doe;
    returnFromInterrupt && dozeOnExit_q |=> dozeEnable_q;
  endproperty
  a_doe: assert property (p_doe) else $error("return did not set doze");

  property p_dbg;
    (state_q == PDC_RUN) && inCircuitDebug |-> cpuClkEn;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug not full speed");

  property p_wake;
    (state_q == PDC_SLEEP) && wakeEvent && regPowerMode_q |=>
      !cpuClkEn [*8] ##[1:200] (state_q == PDC_RUN);
  endproperty
  a_wake: assert property (p_wake) else $error("wake delay wrong");

  property p_nop;
    (state_q == PDC_RUN) && sleepExec && intPending |=> (state_q == PDC_RUN);
  endproperty
  a_nop: assert property (p_nop) else $error("sleep entered with pending interrupt");

  property p_period;
    tickSeen_q && cycleTick |-> ({1'b0, tickGap_q} == ((9'h002 << tickRatio_q) - 9'h001));
  endproperty
  a_period: assert property (p_period) else $error("doze period wrong");

  property p_noret;
    returnFromInterrupt && !dozeOnExit_q && !isrClear && !wrDoze |=> $stable(dozeEnable_q);
  endproperty
  a_noret: assert property (p_noret) else $error("return changed doze");

  property p_dbgkeep;
    inCircuitDebug && !isrClear && !retfieSet && !wrDoze |=> $stable(dozeEnable_q);
  endproperty
  a_dbgkeep: assert property (p_dbgkeep) else $error("debug changed stored doze");

  property p_wakegate;
    (state_q == PDC_WAKE) |-> !cpuClkEn && !periphClkEn && !regLowCurrent;
  endproperty
  a_wakegate: assert property (p_wakegate) else $error("clocks ran during wake delay");

  property p_normwake;
    (state_q == PDC_SLEEP) && wakeEvent && !regPowerMode_q |=> (state_q == PDC_RUN);
  endproperty
  a_normwake: assert property (p_normwake) else $error("normal wake delayed");

  property p_sleepstay;
    (state_q == PDC_SLEEP) && !wakeEvent |=> (state_q == PDC_SLEEP);
  endproperty
  a_sleepstay: assert property (p_sleepstay) else $error("sleep left without wake");

  property p_idlestay;
    (state_q == PDC_IDLE) && !wakeEvent |=> (state_q == PDC_IDLE);
  endproperty
  a_idlestay: assert property (p_idlestay) else $error("idle left without wake");

  property p_wakeidle;
    (state_q == PDC_IDLE) && wakeEvent |=> (state_q == PDC_RUN);
  endproperty
  a_wakeidle: assert property (p_wakeidle) else $error("idle did not wake");

  property p_runstay;
    (state_q == PDC_RUN) && !sleepTaken |=> (state_q == PDC_RUN);
  endproperty
  a_runstay: assert property (p_runstay) else $error("run left without sleep");

  property p_rdzero;
    psel && penable && !pwrite && (hit == 3'b000) |-> (prdata == 32'h00000000);
  endproperty
  a_rdzero: assert property (p_rdzero) else $error("unmapped read not zero");

  c_idle:  cover property ((state_q == PDC_RUN) ##1 (state_q == PDC_IDLE));
  c_sleep: cover property ((state_q == PDC_SLEEP) ##1 (state_q == PDC_WAKE));
  c_doze:  cover property (dozeActive && cpuClkEn ##1 dozeActive && !cpuClkEn);
  c_roi:   cover property (isrEntry && recoverOnInterrupt_q && dozeEnable_q);
  c_nop:   cover property ((state_q == PDC_RUN) && sleepExec && intPending);

endmodule

// ===== core/pdc_cfg.svh
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH

// Register byte offsets
`define PDC_OFS_REGCTL      8'h00
`define PDC_OFS_DOZECTL     8'h04
`define PDC_OFS_STATUS      8'h08

// Regulator control fields
`define PDC_REG_PM_BIT      1
`define PDC_REG_RSVD_BIT    0
`define PDC_REG_PM_RST      1'b0

// Doze and idle control fields
`define PDC_DZ_IDLE_BIT     7
`define PDC_DZ_EN_BIT       6
`define PDC_DZ_ROI_BIT      5
`define PDC_DZ_DOE_BIT      4
`define PDC_DZ_RATIO_MSB    2
`define PDC_DZ_RATIO_LSB    0
`define PDC_DZ_RATIO_RST    3'h0

// Status fields
`define PDC_ST_DOZE_BIT     4
`define PDC_ST_STATE_MSB    3
`define PDC_ST_STATE_LSB    0

// Timing
`define PDC_CLK_NS          10
`define PDC_LP_WAKE_NS      1000
`define PDC_LP_WAKE_CYC     ((`PDC_LP_WAKE_NS + `PDC_CLK_NS - 1) / `PDC_CLK_NS)

`endif

// ===== core/pdc_pkg.sv
package pdc_pkg;

  typedef enum logic [3:0] {
    PDC_RUN   = 4'b0001,
    PDC_IDLE  = 4'b0010,
    PDC_SLEEP = 4'b0100,
    PDC_WAKE  = 4'b1000
  } pdc_state_e;

  typedef logic [2:0] pdc_ratio_t;

endpackage

// ===== core/pdc_doze_throttle.sv
module pdc_doze_throttle
  import pdc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire pdc_ratio_t ratioCode,
  output logic            cycleTick
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [8:0] periodFull;

  // Period of 2 << code peripheral cycles, reload holds period minus one
  assign periodFull = (9'h002 << ratioCode) - 9'h001;
  // New ratio is picked up only at the period boundary
  assign cnt_d      = (cnt_q == 8'h00) ? periodFull[7:0] : cnt_q - 8'h01;
  assign cycleTick  = (cnt_q == 8'h00);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// ===== core/pdc_wake_delay.sv
`include "pdc_cfg.svh"

module pdc_wake_delay
  import pdc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic start,
  output logic      done
);

  localparam logic [7:0] WAKE_CYC = 8'(`PDC_LP_WAKE_CYC);

  logic [7:0] cnt_q;

  assign done = (cnt_q == 8'h01);

  // Stabilisation count after a low-current sleep
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
    end else if (start) begin
      cnt_q <= WAKE_CYC;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

endmodule

// ===== sim/pdc_core_model.sv
module pdc_core_model (
  input  wire logic   core_clk,
  input  wire logic   resetn,
  input  wire logic   cpuClkEn,
  output logic [31:0] cpuCycles
);
  timeunit 1ns;
  timeprecision 1ps;

  // Instruction cycles the core really executes
  always @(posedge core_clk) begin
    if (!resetn)
      cpuCycles <= 32'h0;
    else if (cpuClkEn)
      cpuCycles <= cpuCycles + 32'h1;
  end
endmodule

// ===== sim/test_pdc_power_ctrl.sv
module test_pdc_power_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import pdc_pkg::*;
  logic        core_clk = 0, resetn = 0, powerOnReset = 1, psel = 0, penable = 0;
  logic        pwrite = 0, sleepExec = 0, intPending = 0, wakeEvent = 0, isrEntry = 0;
  logic        returnFromInterrupt = 0, inCircuitDebug = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, cpuCycles, rd, c0;
  logic        pready, pslverr, err, cpuClkEn, periphClkEn, regLowCurrent;
  int          fail_count = 0, n_compared = 0, n;

  pdc_power_ctrl u_pdc_power_ctrl (.core_clk, .resetn, .powerOnReset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleepExec, .intPending,
    .wakeEvent, .isrEntry, .returnFromInterrupt, .inCircuitDebug, .cpuClkEn,
    .periphClkEn, .regLowCurrent);
  pdc_core_model u_pdc_core_model (.core_clk, .resetn, .cpuClkEn, .cpuCycles);

  always #5 core_clk = ~core_clk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One-cycle pulse on {wake, return, isr, sleep}
  task pulse(input logic [3:0] m);
    @(posedge core_clk);
    {wakeEvent, returnFromInterrupt, isrEntry, sleepExec} <= m;
    @(posedge core_clk);
    {wakeEvent, returnFromInterrupt, isrEntry, sleepExec} <= 4'h0;
    #1;
    n = 0;
    while (m[3] && cpuClkEn !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask

  task window(input int len);
    #1;
    c0 = cpuCycles;
    repeat (len) @(posedge core_clk);
    #1;
  endtask

  task t_regs;
    apb(0, 8'h04, 32'h0);
    check(rd, 32'h00);
    apb(0, 8'h08, 32'h0);
    check(rd, 32'h01);
    apb(0, 8'h00, 32'h0);
    check(rd, 32'h01);
    apb(1, 8'h00, 32'h03);
    apb(0, 8'h00, 32'h0);
    check(rd, 32'h03);
    apb(1, 8'h04, 32'hFF);
    apb(0, 8'h04, 32'h0);
    check(rd, 32'hF7);
    apb(0, 8'h08, 32'h0);
    check(rd, 32'h11);
    apb(0, 8'h0C, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
  endtask

  task t_sleep;
    apb(1, 8'h04, 32'h80);
    pulse(4'h1);
    check(32'({cpuClkEn, periphClkEn, regLowCurrent}), 32'h2);
    pulse(4'h8);
    check(n, 0);
    apb(1, 8'h04, 32'h00);
    pulse(4'h1);
    check(32'({cpuClkEn, periphClkEn, regLowCurrent}), 32'h1);
    apb(0, 8'h08, 32'h0);
    check(rd, 32'h04);
    pulse(4'h8);
    check(32'(n >= 100 && n <= 101), 32'h1);
    apb(1, 8'h00, 32'h01);
    pulse(4'h1);
    check(32'({cpuClkEn, periphClkEn, regLowCurrent}), 32'h0);
    pulse(4'h8);
    check(n, 0);
    @(posedge core_clk);
    intPending <= 1'b1;
    pulse(4'h1);
    check(32'({cpuClkEn, periphClkEn, regLowCurrent}), 32'h6);
    intPending <= 1'b0;
  endtask

  task t_doze;
    for (int r = 0; r < 8; r++) begin
      apb(1, 8'h04, 32'h40 | r);
      window(512);
      window(4 * (2 << r));
      check(cpuCycles - c0, 32'h4);
    end
    @(posedge core_clk);
    inCircuitDebug <= 1'b1;
    window(17);
    window(16);
    check(cpuCycles - c0, 32'd16);
    apb(0, 8'h04, 32'h0);
    check(rd, 32'h47);
    apb(0, 8'h08, 32'h0);
    check(rd, 32'h01);
    inCircuitDebug <= 1'b0;
    apb(1, 8'h04, 32'h00);
    window(16);
    check(cpuCycles - c0, 32'd16);
  endtask

  task t_isr;
    apb(1, 8'h04, 32'h60);
    pulse(4'h2);
    apb(0, 8'h04, 32'h0);
    check(rd, 32'h20);
    apb(1, 8'h04, 32'h40);
    pulse(4'h2);
    apb(0, 8'h04, 32'h0);
    check(rd, 32'h40);
    apb(1, 8'h04, 32'h10);
    pulse(4'h4);
    apb(0, 8'h04, 32'h0);
    check(rd, 32'h50);
    apb(1, 8'h04, 32'h00);
    pulse(4'h4);
    apb(0, 8'h04, 32'h0);
    check(rd, 32'h00);
  endtask

  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end

  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    powerOnReset <= 1'b0;
    #1;
    check(32'({cpuClkEn, periphClkEn, regLowCurrent}), 32'h6);
    t_regs;
    t_sleep;
    t_doze;
    t_isr;
    give_verdict;
  end
endmodule
